/* common/wati_pkg.sv */
package wati_pkg;

  // ----------------------------------------------------------------
  // widths and limits
  // ----------------------------------------------------------------
  localparam int          WORD_W     = 16;                // data word width
  localparam int          ADDR_W     = 16;                // word address width
  localparam int          CNT_W      = 11;                // table length, up to 1024
  localparam int          TABLE_MAX  = 1024;             // longest table in words
  localparam logic [15:0] SAT_MAX    = 16'h7fff;          // +32767
  localparam logic [15:0] SAT_MIN    = 16'h8000;          // -32768
  localparam logic [15:0] NEG_ONE    = 16'h ffff;         // -1
  localparam logic [15:0] WORD_ZERO  = 16'h0000;          // zero word
  localparam logic [15:0] ADDR_ZERO  = 16'h0000;          // zero address
  localparam logic [10:0] CNT_ZERO   = 11'h000;           // empty count
  localparam logic [10:0] CNT_ONE    = 11'h001;           // one word left

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_TABLE_INVERT = 3'h0,                               // table_invert_copy
    OP_ADD          = 3'h1,                               // saturating add
    OP_SUB          = 3'h2,                               // saturating subtract
    OP_MUL          = 3'h3,                               // double-length multiply
    OP_DIV          = 3'h4                                // quotient and remainder
  } wati_op_t;

  // ----------------------------------------------------------------
  // request from the scan sequencer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                valid;                           // one-cycle issue strobe
    logic                enable;                          // rung input level
    wati_op_t            op;                              // operation
    logic [WORD_W-1:0]   a;                               // first operand
    logic [WORD_W-1:0]   b;                               // second operand
    logic [ADDR_W-1:0]   src;                             // table source start
    logic [ADDR_W-1:0]   dst;                             // table destination start
    logic [CNT_W-1:0]    count;                           // table length
  } wati_req_t;

  // ----------------------------------------------------------------
  // answer to the scan sequencer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                done;                            // one-cycle completion
    logic                out_on;                          // rung output level
    logic                wr_lo;                           // write dest word
    logic                wr_hi;                           // write dest word plus one
    logic [WORD_W-1:0]   lo;                              // dest word value
    logic [WORD_W-1:0]   hi;                              // dest plus one value
  } wati_res_t;

  // ----------------------------------------------------------------
  // word memory port
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                rd_en;                           // read, data next cycle
    logic                wr_en;                           // write strobe
    logic [ADDR_W-1:0]   addr;                            // word address
    logic [WORD_W-1:0]   wdata;                           // write data
  } wati_mem_t;

  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,                                    // waiting for request
    ST_READ  = 3'b010,                                    // fetch source word
    ST_WRITE = 3'b100                                     // store inverted word
  } wati_state_t;

endpackage

/* hw/wati_unit.sv */
`timescale 1ns/1ps
`default_nettype none

module wati_unit (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire wati_pkg::wati_req_t req,
  input  wire logic             fault_clr,
  input  wire logic [15:0]      mem_rdata,
  output logic                  ready,
  output wati_pkg::wati_res_t   res,
  output wati_pkg::wati_mem_t   mem,
  output logic                  instruction_fault_flag
);
  import wati_pkg::*;

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    wati_state_t         st;                              // sequencer state
    logic [ADDR_W-1:0]   src;                             // next source address
    logic [ADDR_W-1:0]   dst;                             // next destination address
    logic [CNT_W-1:0]    left;                            // words still to move
    logic                down;                            // walk addresses downward
    logic                ready;                           // registered ready
    wati_res_t           res;                             // registered answer
    wati_mem_t           mem;                             // registered memory port
    logic                fault;                           // sticky fault flag
    logic                rd_wait;                         // read pulse done, data now on mem_rdata
  } wati_regs_t;

  wati_regs_t          s_r;                               // current state
  wati_regs_t          s_nxt;                             // next state

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  logic signed [16:0]  sum17;                             // widened sum
  logic signed [16:0]  dif17;                             // widened difference
  logic signed [31:0]  prod;                              // full product
  logic signed [15:0]  div_b;                             // divisor, never zero
  logic signed [15:0]  quo;                               // quotient
  logic signed [15:0]  rem;                               // remainder
  logic                div_edge;                          // -32768 by -1 case
  logic [ADDR_W-1:0]   last_ofs;                          // count minus one
  logic                fault_set;                         // zero divisor taken this cycle

  // operands widened by sign, never by zero
  always_comb begin
    sum17    = $signed({req.a[15], req.a}) + $signed({req.b[15], req.b});
    dif17    = $signed({req.a[15], req.a}) - $signed({req.b[15], req.b});
    prod     = $signed(req.a) * $signed(req.b);
    div_edge = (req.a == SAT_MIN) && (req.b == NEG_ONE);
    div_b    = (req.b == WORD_ZERO || div_edge) ? 16'sh0001 : $signed(req.b);
    quo      = $signed(req.a) / div_b;                    // truncates toward zero
    rem      = $signed(req.a) % div_b;
    last_ofs = ADDR_W'(req.count) - 16'h0001;
    fault_set = (s_r.st == ST_IDLE) && req.valid && req.enable && (req.op == OP_DIV) && (req.b == WORD_ZERO);
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt           = s_r;
    s_nxt.res.done  = 1'b0;                               // pulses by default
    s_nxt.res.wr_lo = 1'b0;
    s_nxt.res.wr_hi = 1'b0;
    s_nxt.mem.rd_en = 1'b0;
    s_nxt.mem.wr_en = 1'b0;

    unique case (s_r.st)
      ST_IDLE: begin
        if (req.valid) begin
          // every taken request answers with done
          s_nxt.res.done   = 1'b1;
          s_nxt.res.out_on = 1'b0;
          s_nxt.res.lo     = WORD_ZERO;
          s_nxt.res.hi     = WORD_ZERO;
          if (!req.enable) begin
            s_nxt.res.out_on = 1'b0;
          end else begin
            unique case (req.op)
              OP_ADD: begin
                s_nxt.res.wr_lo = 1'b1;
                if (sum17[16] != sum17[15]) begin
                  s_nxt.res.lo     = sum17[16] ? SAT_MIN : SAT_MAX;
                  s_nxt.res.out_on = 1'b1;
                end else begin
                  s_nxt.res.lo     = sum17[15:0];
                end
              end
              OP_SUB: begin
                s_nxt.res.wr_lo = 1'b1;
                if (dif17[16] != dif17[15]) begin
                  s_nxt.res.lo     = dif17[16] ? SAT_MIN : SAT_MAX;
                  s_nxt.res.out_on = 1'b1;
                end else begin
                  s_nxt.res.lo     = dif17[15:0];
                end
              end
              OP_MUL: begin
                s_nxt.res.wr_lo  = 1'b1;
                s_nxt.res.wr_hi  = 1'b1;
                s_nxt.res.lo     = prod[15:0];
                s_nxt.res.hi     = prod[31:16];
                s_nxt.res.out_on = 1'b1;
              end
              OP_DIV: begin
                if (req.b == WORD_ZERO) begin
                  s_nxt.res.out_on = 1'b0;
                  s_nxt.fault      = 1'b1;
                end else begin
                  s_nxt.res.wr_lo  = 1'b1;
                  s_nxt.res.wr_hi  = 1'b1;
                  s_nxt.res.lo     = div_edge ? SAT_MIN : quo;
                  s_nxt.res.hi     = div_edge ? WORD_ZERO : rem;
                  s_nxt.res.out_on = 1'b1;
                end
              end
              OP_TABLE_INVERT: begin
                if (req.count == CNT_ZERO) begin
                  s_nxt.res.out_on = 1'b1;                // empty table: nothing moves
                end else begin
                  // done comes at the end of the copy instead
                  s_nxt.res.done = 1'b0;
                  s_nxt.ready    = 1'b0;
                  s_nxt.left     = req.count;
                  s_nxt.st       = ST_READ;
                  // walk down when destination lies above source
                  s_nxt.down     = (req.dst > req.src);
                  s_nxt.src      = s_nxt.down ? req.src + last_ofs : req.src;
                  s_nxt.dst      = s_nxt.down ? req.dst + last_ofs : req.dst;
                end
              end
              default: begin
                s_nxt.res.out_on = 1'b0;                  // unknown code: nothing runs
              end
            endcase
          end
        end
      end
      ST_READ: begin
        // fetch one source word before its slot can be overwritten
        s_nxt.mem.rd_en = 1'b1;
        s_nxt.mem.addr  = s_r.src;
        s_nxt.st        = ST_WRITE;
      end
      ST_WRITE: begin
        if (!s_r.rd_wait) begin
          // read pulse is on the port now; the word lands next cycle
          s_nxt.rd_wait   = 1'b1;
        end else begin
          // read data is on mem_rdata now; store it inverted
          s_nxt.rd_wait   = 1'b0;
          s_nxt.mem.wr_en = 1'b1;
          s_nxt.mem.addr  = s_r.dst;
          s_nxt.mem.wdata = ~mem_rdata;
          s_nxt.src       = s_r.down ? s_r.src - 16'h0001 : s_r.src + 16'h0001;
          s_nxt.dst       = s_r.down ? s_r.dst - 16'h0001 : s_r.dst + 16'h0001;
          s_nxt.left      = s_r.left - CNT_ONE;
          if (s_r.left == CNT_ONE) begin
            s_nxt.st         = ST_IDLE;
            s_nxt.ready      = 1'b1;
            s_nxt.res.done   = 1'b1;
            s_nxt.res.out_on = 1'b1;
          end else begin
            s_nxt.st         = ST_READ;
          end
        end
      end
      default: begin
        s_nxt.st    = ST_IDLE;                            // illegal code recovers
        s_nxt.ready = 1'b1;
      end
    endcase

    // only an explicit clear drops the flag; a new fault wins
    if (fault_clr && !fault_set) begin
      s_nxt.fault = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r       <= '0;
      s_r.st    <= ST_IDLE;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  assign ready                  = s_r.ready;
  assign res                    = s_r.res;
  assign mem                    = s_r.mem;
  assign instruction_fault_flag = s_r.fault;

endmodule

`default_nettype wire

/* test/wati_unit_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module wati_unit_checker (
  input wire logic                instruction_fault_flag,
  input wire logic                clk,
  input wire logic                rst,
  input wire wati_pkg::wati_req_t req,
  input wire logic                fault_clr,
  input wire logic [15:0]         mem_rdata,
  input wire logic                ready,
  input wire wati_pkg::wati_res_t res,
  input wire wati_pkg::wati_mem_t mem
);
  import wati_pkg::*;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic        tk;               // enabled request taken
  logic [16:0] e_add;            // {clamped, word}
  logic [16:0] e_sub;            // {clamped, word}
  logic [31:0] prod;             // signed product
  logic [15:0] q;                // truncated quotient
  logic [15:0] r;                // remainder
  // clamp a 17-bit signed sum to 16 bits
  function automatic logic [16:0] sat(input logic [16:0] s);
    return (s[16] != s[15]) ? {1'b1, s[16] ? SAT_MIN : SAT_MAX} : {1'b0, s[15:0]};
  endfunction
  assign tk = req.valid && ready && req.enable;
  assign e_add = sat({req.a[15], req.a} + {req.b[15], req.b});
  assign e_sub = sat({req.a[15], req.a} - {req.b[15], req.b});
  assign prod = $signed(req.a) * $signed(req.b);
  assign q = $signed(req.a) / $signed(req.b);
  assign r = $signed(req.a) % $signed(req.b);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_off; req.valid && ready && !req.enable |=> res.done && !res.out_on && !res.wr_lo && !res.wr_hi; endproperty
  a_off: assert property (p_off) else $error("disabled op acted");
  property p_add; tk && req.op == OP_ADD |=> res.wr_lo && {res.out_on, res.lo} == $past(e_add); endproperty
  a_add: assert property (p_add) else $error("add result wrong");
  property p_sub; tk && req.op == OP_SUB |=> res.wr_lo && {res.out_on, res.lo} == $past(e_sub); endproperty
  a_sub: assert property (p_sub) else $error("sub result wrong");
  property p_mul; tk && req.op == OP_MUL |=> res.out_on && res.wr_hi && {res.hi, res.lo} == $past(prod); endproperty
  a_mul: assert property (p_mul) else $error("mul result wrong");
  property p_div; tk && req.op == OP_DIV && req.b != 0 && !(req.a == SAT_MIN && req.b == NEG_ONE)
    |=> res.out_on && res.lo == $past(q) && res.hi == $past(r); endproperty
  a_div: assert property (p_div) else $error("div result wrong");
  property p_dovf; tk && req.op == OP_DIV && req.a == SAT_MIN && req.b == NEG_ONE
    |=> res.out_on && res.lo == SAT_MIN && res.hi == WORD_ZERO; endproperty
  a_dovf: assert property (p_dovf) else $error("div limit case wrong");
  property p_dz; tk && req.op == OP_DIV && req.b == 0 |=> instruction_fault_flag && !res.out_on && !res.wr_lo; endproperty
  a_dz: assert property (p_dz) else $error("zero divisor handled wrong");
  property p_hold; instruction_fault_flag && !fault_clr |=> instruction_fault_flag; endproperty
  a_hold: assert property (p_hold) else $error("fault flag dropped");
  property p_pair; mem.rd_en |=> !mem.wr_en ##1 mem.wr_en; endproperty
  a_pair: assert property (p_pair) else $error("read not followed by write");
  property p_busy; tk && req.op == OP_TABLE_INVERT && req.count != CNT_ZERO |=> !ready && !res.done; endproperty
  a_busy: assert property (p_busy) else $error("not busy during table copy");
endmodule
bind wati_unit wati_unit_checker i_chk (.clk(clk), .rst(rst), .req(req), .fault_clr(fault_clr),
  .mem_rdata(mem_rdata), .ready(ready), .res(res), .mem(mem), .instruction_fault_flag(instruction_fault_flag));
`default_nettype wire

/* test/wati_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wati_mem_model (
  input wire logic                clk,
  input wire wati_pkg::wati_mem_t mem,
  output logic [15:0]             mem_rdata
);
  logic [15:0] ram [64];         // word store, preloaded by bench
  // sync ram: data valid only the cycle after a read
  always @(posedge clk) begin
    if (mem.wr_en) ram[mem.addr[5:0]] <= mem.wdata;
    if (mem.rd_en) mem_rdata <= ram[mem.addr[5:0]];
    else mem_rdata <= ~mem_rdata;
  end
endmodule
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wati_pkg::*;
  logic        clk, rst, fault_clr, ready, flag;
  logic [15:0] mem_rdata;
  wati_req_t   req;
  wati_res_t   res;
  wati_mem_t   mem;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_wait = 0;
  logic [15:0] v [5] = '{16'h00ff, 16'h0000, 16'h1234, 16'h5555, 16'h89ab};
  wati_unit i_dut (.clk(clk), .rst(rst), .req(req), .fault_clr(fault_clr), .mem_rdata(mem_rdata),
    .ready(ready), .res(res), .mem(mem), .instruction_fault_flag(flag));
  wati_mem_model i_mem (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one request, then wait for done under a bound
  task automatic issue(input wati_op_t op, input logic en, input logic [15:0] a, b, s, d, input logic [10:0] n);
    int i;
    @(negedge clk);
    req = '{1'b1, en, op, a, b, s, d, n};
    @(negedge clk);
    req.valid = 1'b0;
    i = 0;
    while (res.done !== 1'b1 && i < 3000) begin
      @(negedge clk);
      i++;
    end
    if (i == 3000) n_mismatch++;
    n_wait = i;
  endtask
  task automatic arith(input wati_op_t op, input logic [15:0] a, b, lo, hi, input logic on);
    issue(op, 1'b1, a, b, ADDR_ZERO, ADDR_ZERO, CNT_ZERO);
    chk(res.lo, lo);
    chk({15'h0000, res.out_on}, {15'h0000, on});
    if (op == OP_MUL || op == OP_DIV) chk(res.hi, hi);
  endtask
  // every op with the rung off, zero divisor included
  task automatic t_off;
    for (int k = 0; k < 5; k++) begin
      issue(wati_op_t'(k), 1'b0, SAT_MAX, WORD_ZERO, ADDR_ZERO, ADDR_ZERO, CNT_ONE);
      chk({11'h000, flag, res.done, res.out_on, res.wr_lo, res.wr_hi}, 16'h0008);
    end
    issue(wati_op_t'(3'h5), 1'b1, SAT_MAX, NEG_ONE, ADDR_ZERO, ADDR_ZERO, CNT_ONE);
    chk({11'h000, flag, res.done, res.out_on, res.wr_lo, res.wr_hi}, 16'h0008);
    $display("test off done");
  endtask
  task automatic t_arith;
    arith(OP_ADD, 16'h3039, 16'h03e8, 16'h3421, WORD_ZERO, 1'b0);
    arith(OP_ADD, 16'h7fbc, 16'h03e8, SAT_MAX, WORD_ZERO, 1'b1);
    arith(OP_ADD, 16'h8300, 16'hfc18, SAT_MIN, WORD_ZERO, 1'b1);
    arith(OP_ADD, SAT_MIN, SAT_MAX, NEG_ONE, WORD_ZERO, 1'b0);
    arith(OP_SUB, 16'h3a98, 16'h09c4, 16'h30d4, WORD_ZERO, 1'b0);
    arith(OP_SUB, 16'h86e8, 16'h09c4, SAT_MIN, WORD_ZERO, 1'b1);
    arith(OP_SUB, SAT_MAX, NEG_ONE, SAT_MAX, WORD_ZERO, 1'b1);
    arith(OP_MUL, 16'h05dc, 16'h0014, 16'h7530, WORD_ZERO, 1'b1);
    arith(OP_MUL, 16'hfffe, 16'h0003, 16'hfffa, NEG_ONE, 1'b1);
    arith(OP_MUL, SAT_MIN, SAT_MIN, WORD_ZERO, 16'h4000, 1'b1);
    arith(OP_DIV, 16'h0b4e, 16'h0145, 16'h0008, 16'h0126, 1'b1);
    arith(OP_DIV, 16'hfff9, 16'h0002, 16'hfffd, NEG_ONE, 1'b1);
    arith(OP_DIV, SAT_MIN, NEG_ONE, SAT_MIN, WORD_ZERO, 1'b1);
    $display("test arith done");
  endtask
  // zero divisor sets a sticky flag
  task automatic t_div0;
    issue(OP_DIV, 1'b1, 16'h0064, WORD_ZERO, ADDR_ZERO, ADDR_ZERO, CNT_ZERO);
    chk({12'h000, flag, res.out_on, res.wr_lo, res.wr_hi}, 16'h0008);
    arith(OP_DIV, 16'h0064, 16'h0005, 16'h0014, WORD_ZERO, 1'b1);
    repeat (3) @(negedge clk);
    chk({15'h0000, flag}, 16'h0001);
    fault_clr = 1'b1;
    @(negedge clk);
    fault_clr = 1'b0;
    @(negedge clk);
    chk({15'h0000, flag}, 16'h0000);
    issue(OP_DIV, 1'b1, 16'h0064, WORD_ZERO, ADDR_ZERO, ADDR_ZERO, CNT_ZERO);
    // a new fault and a clear in one cycle: the fault wins
    @(negedge clk);
    req = '{1'b1, 1'b1, OP_DIV, 16'h0064, WORD_ZERO, ADDR_ZERO, ADDR_ZERO, CNT_ZERO};
    fault_clr = 1'b1;
    @(negedge clk);
    req.valid = 1'b0;
    fault_clr = 1'b0;
    chk({15'h0000, flag}, 16'h0001);
    $display("test div0 done");
  endtask
  // load v at s, invert-copy n words to d, check d
  task automatic tbl(input logic [15:0] s, d, input logic [10:0] n);
    for (int k = 0; k < n; k++) i_mem.ram[s[5:0] + k] = v[k];
    issue(OP_TABLE_INVERT, 1'b1, WORD_ZERO, WORD_ZERO, s, d, n);
    chk({14'h0000, ready, res.out_on}, 16'h0003);
    chk(16'(n_wait), 16'(3 * n));
    @(negedge clk);
    for (int k = 0; k < n; k++) chk(i_mem.ram[d[5:0] + k], ~v[k]);
  endtask
  task automatic t_table;
    tbl(16'h0000, 16'h0008, 11'h005);
    tbl(16'h0014, 16'h0016, 11'h004);
    tbl(16'h0022, 16'h0020, 11'h004);
    issue(OP_TABLE_INVERT, 1'b1, WORD_ZERO, WORD_ZERO, ADDR_ZERO, ADDR_ZERO, CNT_ZERO);
    chk({14'h0000, res.done, res.out_on}, 16'h0003);
    $display("test table done");
  endtask
  initial begin
    rst = 1'b1;
    fault_clr = 1'b0;
    req = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_off;
    t_arith;
    t_div0;
    t_table;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
endmodule
`default_nettype wire
